// file: logic/pulse_modulator_channel.sv
`include "pwm_defs.svh"

module pulse_modulator_channel import pwm_pkg::*; #(
  parameter int FRAC_BITS = `DUTY_FRAC_BITS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [`PERIOD_W-1:0] period,
  input wire logic [`DUTY_W-1:0] duty,
  input wire logic [`PERIOD_W-1:0] sample_time,
  input wire logic restart,
  output logic [`PERIOD_W-1:0] ramp_count,
  output logic [`PERIOD_W-1:0] threshold,
  output logic gate,
  output logic period_start,
  output logic sample_strobe
);

  // ****************************************
  // Threshold and ramp decode
  // ****************************************
  wire [`PERIOD_W+`DUTY_W-1:0] product = duty * period;
  wire [`PERIOD_W:0] scaled = product[FRAC_BITS +: `PERIOD_W + 1];
  wire [`PERIOD_W-1:0] next_threshold = (scaled > {1'b0, period}) ? period : scaled[`PERIOD_W-1:0];
  wire [`PERIOD_W:0] count_plus = {1'b0, ramp_count} + 17'h00001;
  wire at_end = count_plus >= {1'b0, period};
  wire [`PERIOD_W-1:0] next_ramp = (restart || at_end) ? '0 : count_plus[`PERIOD_W-1:0];
  wire sample_hit = (sample_time != '0) && (sample_time <= period) && (ramp_count == period - sample_time);

  // ****************************************
  // Ramp counter and gate
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ramp_count <= '0;
      threshold <= '0;
      gate <= 1'b0;
      period_start <= 1'b0;
      sample_strobe <= 1'b0;
    end else if (!enable) begin
      ramp_count <= '0;
      threshold <= '0;
      gate <= 1'b0;
      period_start <= 1'b0;
      sample_strobe <= 1'b0;
    end else begin
      threshold <= next_threshold;
      ramp_count <= next_ramp;
      gate <= ramp_count < threshold;
      period_start <= restart || at_end;
      sample_strobe <= sample_hit;
    end
  end

endmodule

// file: logic/pwm_defs.svh
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH

// ****************************************
// Sizes
// ****************************************
`define NUM_CH 4
`define MAX_RAILS 2
`define SEL_W 3
`define PERIOD_W 16
`define DUTY_W 16
`define DELAY_W 8
`define DUTY_FRAC_BITS 15

// ****************************************
// Sync source and sync output codes
// ****************************************
`define SRC_NONE 3'h0
`define SRC_EXT 3'h5
`define OUT_OFF 3'h0

// ****************************************
// Reset values
// ****************************************
`define SYNC_SEL_RST 3'h0
`define DELAY_RST 8'h00

`endif

// file: logic/pwm_pkg.sv
`include "pwm_defs.svh"

package pwm_pkg;

  typedef logic [`SEL_W-1:0] sel_t;

  typedef struct packed {
    logic [`PERIOD_W-1:0] period;
    logic [`DUTY_W-1:0] duty;
    logic [`PERIOD_W-1:0] sample_time;
    logic [`DELAY_W-1:0] phase_trigger_delay;
  } engine_cfg_s;

  typedef struct packed {
    sel_t [`NUM_CH-1:0] src_sel;
    sel_t out_sel;
  } sync_cfg_s;

endpackage

// file: logic/synced_pwm_engine_array.sv
// Function
// - Threshold is duty word times configured period, shifted right by 15 bits and capped at the period.
// - Gate high while ramp below threshold.
// - Ramp reset source: none, engine, sync input.
// - Sync output source: off or one engine.
// - Selected sync event restarts the ramp counter.
// - External sync uses separate delay; others phase delay.
// - At most two rails, output channel equals sense.
// - Sync routing applied from vendor extension command.
// - Error sample strobe at programmed ramp point.
`include "pwm_defs.svh"

module synced_pwm_engine_array import pwm_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire engine_cfg_s [`NUM_CH-1:0] engine_cfg,
  input wire logic [`NUM_CH-1:0] rail_enable,
  input wire logic [`DELAY_W-1:0] external_sync_delay_reg,
  input wire sync_cfg_s vendor_extension_command,
  input wire logic vendor_extension_valid,
  input wire logic sync_input_pin,
  output logic sync_output_pin,
  output logic [`NUM_CH-1:0] gate_out,
  output logic [`NUM_CH-1:0] error_sample_strobe,
  output logic [`NUM_CH-1:0] rail_active,
  output sync_cfg_s sync_cfg
);

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic engine_pulse(input sel_t sel, input logic [`NUM_CH-1:0] starts);
    logic res;
    res = 1'b0;
    for (int k = 0; k < `NUM_CH; k++) begin
      if (sel == sel_t'(k + 1)) begin
        res = starts[k];
      end
    end
    return res;
  endfunction

  // ****************************************
  // Signals
  // ****************************************
  logic sync_meta;
  logic sync_stage;
  logic sync_prev;
  logic [`NUM_CH-1:0] period_start;
  logic [`NUM_CH-1:0] restart;
  logic [`NUM_CH-1:0] src_event;
  logic [`NUM_CH-1:0][`DELAY_W-1:0] dly_cnt;
  logic [`NUM_CH-1:0][`DELAY_W-1:0] dly_sel;
  logic [`NUM_CH-1:0][`PERIOD_W-1:0] ramp_count;
  logic [`NUM_CH-1:0][`PERIOD_W-1:0] threshold;
  logic [`NUM_CH-1:0] chan_gate;
  logic [`NUM_CH-1:0] allowed;
  wire sync_edge = sync_stage && !sync_prev;

  // ****************************************
  // Sync input capture
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_meta <= 1'b0;
      sync_stage <= 1'b0;
      sync_prev <= 1'b0;
    end else begin
      sync_meta <= sync_input_pin;
      sync_stage <= sync_meta;
      sync_prev <= sync_stage;
    end
  end

  // ****************************************
  // Sync routing command
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_cfg <= '{src_sel: {`NUM_CH{`SYNC_SEL_RST}}, out_sel: `OUT_OFF};
    end else if (vendor_extension_valid) begin
      sync_cfg <= vendor_extension_command;
    end
  end

  // ****************************************
  // Rail limit
  // ****************************************
  always_comb begin
    int used;
    used = 0;
    for (int i = 0; i < `NUM_CH; i++) begin
      allowed[i] = rail_enable[i] && (used < `MAX_RAILS);
      used = used + int'(rail_enable[i]);
    end
  end
  assign rail_active = allowed;

  // ****************************************
  // Engines with sync reset and delay
  // ****************************************
  for (genvar i = 0; i < `NUM_CH; i++) begin : g_ch
    wire sel_t sel = sync_cfg.src_sel[i];
    wire is_ext = sel == `SRC_EXT;
    wire self_sel = sel == sel_t'(i + 1);
    assign src_event[i] = is_ext ? sync_edge : (!self_sel && engine_pulse(sel, period_start));
    assign dly_sel[i] = is_ext ? external_sync_delay_reg : engine_cfg[i].phase_trigger_delay;
    assign restart[i] = (src_event[i] && dly_sel[i] == '0) || (dly_cnt[i] == `DELAY_W'(1));

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        dly_cnt[i] <= `DELAY_RST;
      end else if (src_event[i]) begin
        dly_cnt[i] <= dly_sel[i];
      end else if (dly_cnt[i] != '0) begin
        dly_cnt[i] <= dly_cnt[i] - `DELAY_W'(1);
      end
    end

    pulse_modulator_channel u_chan (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .enable(allowed[i]),
      .period(engine_cfg[i].period),
      .duty(engine_cfg[i].duty),
      .sample_time(engine_cfg[i].sample_time),
      .restart(restart[i]),
      .ramp_count(ramp_count[i]),
      .threshold(threshold[i]),
      .gate(chan_gate[i]),
      .period_start(period_start[i]),
      .sample_strobe(error_sample_strobe[i])
    );
  end

  assign gate_out = chan_gate;

  // ****************************************
  // Sync output
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_output_pin <= 1'b0;
    end else begin
      sync_output_pin <= engine_pulse(sync_cfg.out_sel, period_start);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_threshold;
    allowed[0] ##1 allowed[0] && $stable(engine_cfg[0]) |->
      threshold[0] == ((((32'(engine_cfg[0].duty) * 32'(engine_cfg[0].period)) >> `DUTY_FRAC_BITS)
        > 32'(engine_cfg[0].period)) ? engine_cfg[0].period
        : `PERIOD_W'((32'(engine_cfg[0].duty) * 32'(engine_cfg[0].period)) >> `DUTY_FRAC_BITS));
  endproperty
  a_threshold: assert property (p_threshold) else $error("threshold differs from duty times period");

  property p_gate;
    allowed[0] ##1 allowed[0] |-> gate_out[0] == ($past(ramp_count[0]) < $past(threshold[0]));
  endproperty
  a_gate: assert property (p_gate) else $error("gate does not follow ramp compare");

  sequence s_ext_event;
    sync_edge && sync_cfg.src_sel[0] == `SRC_EXT;
  endsequence
  property p_ext_source;
    (s_ext_event and (external_sync_delay_reg == '0)) |-> restart[0];
  endproperty
  a_ext_source: assert property (p_ext_source) else $error("sync input did not reset ramp");

  property p_sync_out;
    sync_cfg.out_sel == 3'h1 ##1 sync_cfg.out_sel == 3'h1 |-> sync_output_pin == $past(period_start[0]);
  endproperty
  a_sync_out: assert property (p_sync_out) else $error("sync output not from selected engine");

  property p_restart;
    allowed[0] && restart[0] ##1 allowed[0] |-> ramp_count[0] == '0 && period_start[0];
  endproperty
  a_restart: assert property (p_restart) else $error("ramp not restarted by sync event");

  sequence s_delayed_event;
    src_event[0] && dly_sel[0] == `DELAY_W'(2);
  endsequence
  property p_delay;
    s_delayed_event ##1 !src_event[0] |-> !restart[0] ##1 restart[0];
  endproperty
  a_delay: assert property (p_delay) else $error("sync delay not applied");

  property p_rails;
    $countones(gate_out) <= `MAX_RAILS && (rail_active & ~rail_enable) == '0;
  endproperty
  a_rails: assert property (p_rails) else $error("more than two rails active");

  property p_cfg_hold;
    !vendor_extension_valid |=> $stable(sync_cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("sync routing changed without command");

  property p_sample;
    allowed[0] && engine_cfg[0].sample_time != '0 && engine_cfg[0].sample_time <= engine_cfg[0].period &&
      ramp_count[0] == engine_cfg[0].period - engine_cfg[0].sample_time ##1 allowed[0] |-> error_sample_strobe[0];
  endproperty
  a_sample: assert property (p_sample) else $error("error sample strobe missed");

  property p_wrap;
    allowed[0] && !restart[0] && engine_cfg[0].period > 16'h0001 &&
      ramp_count[0] == engine_cfg[0].period - 16'h0001 ##1 allowed[0] |-> ramp_count[0] == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("ramp did not wrap at period end");

endmodule

// file: sim/sync_source_model.sv
module sync_source_model (
  input wire logic clk_sys,
  input wire logic run,
  input wire logic [15:0] gap,
  output logic sync_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // External sync source
  // ****************************************
  // Emits a two-cycle high pulse every gap cycles while run is high.
  logic [15:0] cnt = 16'h0000;
  initial sync_pin = 1'b0;
  always @(negedge clk_sys) begin
    if (!run) begin
      cnt <= 16'h0000;
      sync_pin <= 1'b0;
    end else begin
      cnt <= (cnt + 16'h0001 >= gap) ? 16'h0000 : cnt + 16'h0001;
      sync_pin <= (cnt < 16'h0002);
    end
  end
endmodule

// file: sim/synced_pwm_engine_array_bench.sv
`include "pwm_defs.svh"

module synced_pwm_engine_array_bench import pwm_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Stimulus and observation
  // ****************************************
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  engine_cfg_s [`NUM_CH-1:0] engine_cfg = '0;
  logic [`NUM_CH-1:0] rail_enable = '0;
  logic [`DELAY_W-1:0] ext_delay = 8'h00;
  sync_cfg_s cmd = '0;
  logic cmd_valid = 1'b0;
  logic sync_run = 1'b0;
  logic [15:0] sync_gap = 16'h0019;
  logic sync_pin;
  logic sync_out;
  logic [`NUM_CH-1:0] gate_out, strobe, rail_active;
  sync_cfg_s sync_cfg;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int hi[4], st[4], fr[4], so;
  logic [31:0] rnd = 32'h0adc820e;

  always #5 clk_sys = ~clk_sys;

  synced_pwm_engine_array uut (.clk_sys(clk_sys), .rst_n(rst_n), .engine_cfg(engine_cfg),
    .rail_enable(rail_enable), .external_sync_delay_reg(ext_delay), .vendor_extension_command(cmd),
    .vendor_extension_valid(cmd_valid), .sync_input_pin(sync_pin), .sync_output_pin(sync_out),
    .gate_out(gate_out), .error_sample_strobe(strobe), .rail_active(rail_active), .sync_cfg(sync_cfg));

  sync_source_model far (.clk_sys(clk_sys), .run(sync_run), .gap(sync_gap), .sync_pin(sync_pin));

  // ****************************************
  // Reference model and checks
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int thr(input logic [15:0] duty, input logic [15:0] period);
    longint p;
    longint d;
    p = (period < 16'h0002) ? 1 : longint'(period);
    d = (duty > 16'h8000) ? 32768 : longint'(duty);
    return int'((d * p) >> 15);
  endfunction

  function automatic logic [3:0] keep_two(input logic [3:0] en);
    int n;
    n = 0;
    keep_two = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (en[i] && n < 2) begin
        keep_two[i] = 1'b1;
        n++;
      end
    end
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic route(input sync_cfg_s c);
    cmd = c;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    @(negedge clk_sys);
    cmp(32'(sync_cfg), 32'(c), "routing");
  endtask

  task automatic run_check(input int win, input int out_ch, input string name);
    logic [3:0] act;
    int oc;
    act = keep_two(rail_enable);
    oc = (out_ch + 3) % 4;
    cmp(32'(rail_active), 32'(act), "rail active");
    repeat (100) @(negedge clk_sys);
    hi = '{default: 0};
    st = '{default: 0};
    so = 0;
    repeat (win) begin
      @(negedge clk_sys);
      for (int i = 0; i < 4; i++) begin
        hi[i] += int'(gate_out[i] === 1'b1);
        st[i] += int'(strobe[i] === 1'b1);
      end
      so += int'(sync_out === 1'b1);
    end
    for (int i = 0; i < 4; i++) begin
      cmp(hi[i], act[i] ? win / fr[i] * thr(engine_cfg[i].duty, engine_cfg[i].period) : 0, "gate");
      cmp(st[i], act[i] ? win / fr[i] : 0, "sample strobe");
    end
    cmp(so, (out_ch > 0 && act[oc]) ? win / fr[oc] : 0, "sync out");
    $display("test %s done, mismatches so far %0d", name, n_fail);
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      $display("[ERR] t=%0t run did not finish", $time);
      final_report();
    end
  end

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    sync_cfg_s c;
    int per[4];
    per = '{20, 16, 10, 8};
    rnd = lfsr(rnd);
    for (int i = 0; i < 4; i++) begin
      engine_cfg[i].period = 16'(per[i]);
      engine_cfg[i].sample_time = 16'h0003;
      fr[i] = per[i];
    end
    engine_cfg[0].duty = {1'b0, rnd[14:0]};
    engine_cfg[1].duty = 16'h8000;
    engine_cfg[2].duty = 16'hffff;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    cmp(32'(sync_cfg), 32'h0, "routing after reset");
    for (int n = 0; n < 8; n++) begin
      rnd = lfsr(rnd);
      rail_enable = rnd[3:0];
      @(negedge clk_sys);
      cmp(32'(rail_active), 32'(keep_two(rail_enable)), "rail limit");
    end
    c = '0;
    for (int k = 0; k < 5; k++) begin
      rail_enable = (k > 2) ? 4'hc : 4'hf;
      c.out_sel = 3'(k);
      route(c);
      run_check(80, k, "free run");
    end
    // Chained engines share one period; engine two follows engine one, which ignores its own selection.
    for (int i = 0; i < 4; i++) begin
      engine_cfg[i].period = 16'h0010;
      fr[i] = 16;
    end
    engine_cfg[1].phase_trigger_delay = 8'h05;
    engine_cfg[3].phase_trigger_delay = 8'h05;
    engine_cfg[1].sample_time = 16'h0001;
    rail_enable = 4'h3;
    c.src_sel[0] = 3'h1;
    c.src_sel[1] = 3'h1;
    c.src_sel[3] = 3'h1;
    c.out_sel = 3'h2;
    route(c);
    run_check(80, 2, "chain");
    // External sync frames of 60 cycles are shorter than the 80 cycle period; the phase delay would block restarts.
    engine_cfg[0].period = 16'h0050;
    engine_cfg[0].duty = 16'h4000;
    engine_cfg[0].sample_time = 16'h0030;
    engine_cfg[0].phase_trigger_delay = 8'hc8;
    ext_delay = 8'h02;
    sync_gap = 16'h003c;
    fr[0] = 60;
    rail_enable = 4'h1;
    c.src_sel = '0;
    c.src_sel[0] = `SRC_EXT;
    c.out_sel = 3'h1;
    sync_run = 1'b1;
    route(c);
    run_check(120, 1, "external sync");
    ext_delay = 8'h00;
    run_check(120, 1, "external sync no delay");
    final_report();
  end
endmodule
